// ===== rtl/video_port.sv
// Parallel video output port of the line sensor
//
// Overview of operation
// - Pixel data changes only on a forwarded clock rising edge and only while line valid is high.
// - Line valid changes only together with a forwarded clock rising edge.
// - The pixel word is 8 to 12 bits wide, following the selected conversion width.
// - A line holds 2048 pixels in sensitive mode and 8192 pixels in resolution mode.
// - The line period is programmable, never shorter than one forty-thousandth of a second.
// - Outside test mode the port select pin picks two-wire (high) or three-wire (low) config.
// - Outside test mode the tristate test pin releases every video output.
// - In test mode the port select pin drives row 0 reset and the tristate pin row 1 reset.
// - The configuration port offers a synchronous serial mode and a 16-bit two-wire mode.
// - Pixel words sit left aligned on the twelve data lines, unused low lines at zero.
// - Line valid rises at the first pixel of a line and falls after its last pixel.
`timescale 1ns/1ns
`include "vid_defs.svh"
module video_port (
    // Clocks and reset
    input  wire logic                 MCLK,
    input  wire logic                 RESETN,
    input  wire logic                 LINK_CLK,
    // Pixel source and configuration, same domain as MCLK
    input  wire logic [`PIX_W-1:0]    PIX_DATA,
    input  wire logic [2:0]           ADC_BITS,
    input  wire logic                 RES_MODE,
    input  wire logic [`TIMER_W-1:0]  LINE_PERIOD,
    // Control pins
    input  wire logic                 START,
    input  wire logic                 CFG_SEL,
    input  wire logic                 TRISTATE_TEST_INPUT,
    input  wire logic                 TEST_MODE,
    // Video pins
    output logic [`PIX_W-1:0]         VID_DATA,
    output logic                      VID_DATA_OE,
    output logic                      LINE_VALID,
    output logic                      LINE_VALID_OE,
    output logic                      PIX_CLK,
    output logic                      PIX_CLK_OE,
    // Configuration and test controls
    output logic                      CFG_TWO_WIRE,
    output logic                      ROW0_RESET,
    output logic                      ROW1_RESET
);
    import vid_pkg::*;

    // Left align a right aligned conversion result
    function automatic logic [11:0] align_pix(input logic [11:0] v, input logic [2:0] code);
        logic [2:0] sh;
        sh = (code > `ADC_CODE_MAX) ? 3'h0 : 3'(`ADC_CODE_MAX - code);
        return (v & (12'hFFF >> sh)) << sh;
    endfunction : align_pix

    // ****************************************************************
    // Pin synchronisers, MCLK domain
    // ****************************************************************
    ctl_pins_t                pin_s1_q;
    ctl_pins_t                pin_s2_q;
    logic                     cfg_two_wire_q;
    logic                     cfg_two_wire_d;
    logic                     row0_q;
    logic                     row0_d;
    logic                     row1_q;
    logic                     row1_d;

    always_comb
    begin
        cfg_two_wire_d = pin_s2_q.test ? cfg_two_wire_q : pin_s2_q.sel;
        row0_d         = pin_s2_q.test && pin_s2_q.sel;
        row1_d         = pin_s2_q.test && pin_s2_q.tri_test;
    end

    always_ff @(posedge MCLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            pin_s1_q       <= '0;
            pin_s2_q       <= '0;
            cfg_two_wire_q <= 1'b0;
            row0_q         <= 1'b0;
            row1_q         <= 1'b0;
        end
        else
        begin
            pin_s1_q       <= {START, CFG_SEL, TRISTATE_TEST_INPUT, TEST_MODE};
            pin_s2_q       <= pin_s1_q;
            cfg_two_wire_q <= cfg_two_wire_d;
            row0_q         <= row0_d;
            row1_q         <= row1_d;
        end
    end

    assign CFG_TWO_WIRE = cfg_two_wire_q;
    assign ROW0_RESET   = row0_q;
    assign ROW1_RESET   = row1_q;

    // ****************************************************************
    // Line generator, MCLK domain
    // ****************************************************************
    gen_state_t               state_q;
    gen_state_t               state_d;
    logic [`TIMER_W-1:0]      timer_q;
    logic [`TIMER_W-1:0]      timer_d;
    logic [`TIMER_W-1:0]      period;
    logic [`PCNT_W-1:0]       pcnt_q;
    logic [`PCNT_W-1:0]       pcnt_d;
    logic [`PCNT_W-1:0]       last_idx;
    logic                     lmode_q;
    logic                     lmode_d;
    logic [2:0]               lbits_q;
    logic [2:0]               lbits_d;
    logic                     wr_valid;
    logic                     wr_ready;
    logic                     wr_fire;
    pix_word_t                wr_word;

    always_comb
    begin
        state_d  = state_q;
        timer_d  = (timer_q == 16'hFFFF) ? timer_q : timer_q + 16'h0001;
        pcnt_d   = pcnt_q;
        lmode_d  = lmode_q;
        lbits_d  = lbits_q;
        wr_valid = 1'b0;
        period   = (LINE_PERIOD < `TIMER_W'(`LINE_MIN_CYC)) ?
                   `TIMER_W'(`LINE_MIN_CYC) : LINE_PERIOD;
        last_idx = lmode_q ? `HR_LAST_IDX : `HS_LAST_IDX;
        wr_word.last = (pcnt_q == last_idx);
        wr_word.data = align_pix(PIX_DATA, lbits_q);
        wr_fire  = 1'b0;
        unique case (state_q)
            ST_IDLE:
            begin
                timer_d = `TIMER_RST;
                if (pin_s2_q.start)
                begin
                    state_d = ST_EMIT;
                    pcnt_d  = `PCNT_RST;
                    lmode_d = RES_MODE;
                    lbits_d = ADC_BITS;
                end
            end
            ST_EMIT:
            begin
                wr_valid = 1'b1;
                wr_fire  = wr_ready;
                if (wr_ready)
                begin
                    pcnt_d = pcnt_q + 13'h0001;
                    if (wr_word.last)
                        state_d = ST_GAP;
                end
            end
            ST_GAP:
            begin
                if (timer_q >= period - 16'h0001)
                begin
                    timer_d = `TIMER_RST;
                    pcnt_d  = `PCNT_RST;
                    lmode_d = RES_MODE;
                    lbits_d = ADC_BITS;
                    state_d = pin_s2_q.start ? ST_EMIT : ST_IDLE;
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge MCLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            state_q <= ST_IDLE;
            timer_q <= `TIMER_RST;
            pcnt_q  <= `PCNT_RST;
            lmode_q <= 1'b0;
            lbits_q <= `ADC_CODE_MAX;
        end
        else
        begin
            state_q <= state_d;
            timer_q <= timer_d;
            pcnt_q  <= pcnt_d;
            lmode_q <= lmode_d;
            lbits_q <= lbits_d;
        end
    end

    // ****************************************************************
    // Pixel FIFO into the link domain
    // ****************************************************************
    logic                     lrst_s1_q;
    logic                     lrst_n_q;
    logic                     rd_valid;
    logic                     rd_ready;
    pix_word_t                rd_word;

    always_ff @(posedge LINK_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            lrst_s1_q <= 1'b0;
            lrst_n_q  <= 1'b0;
        end
        else
        begin
            lrst_s1_q <= 1'b1;
            lrst_n_q  <= lrst_s1_q;
        end
    end

    vid_fifo #(
        .WIDTH (`WORD_W),
        .DEPTH (`FIFO_DEPTH)
    ) u_fifo (
        .wclk   (MCLK),
        .wrst_n (RESETN),
        .wdata  (wr_word),
        .wvalid (wr_valid),
        .wready (wr_ready),
        .rclk   (LINK_CLK),
        .rrst_n (lrst_n_q),
        .rdata  (rd_word),
        .rvalid (rd_valid),
        .rready (rd_ready)
    );

    // ****************************************************************
    // Link side output stage, LINK_CLK domain
    // ****************************************************************
    logic                     tri_s1_q;
    logic                     tri_s2_q;
    logic                     tst_s1_q;
    logic                     tst_s2_q;
    logic                     pclk_q;
    logic                     pclk_d;
    logic                     rdy_q;
    logic                     rdy_d;
    logic                     last_q;
    logic                     last_d;
    logic [`PIX_W-1:0]        vdata_q;
    logic [`PIX_W-1:0]        vdata_d;
    logic                     oe_q;
    logic                     oe_d;

    always_comb
    begin
        pclk_d   = 1'b0;
        rdy_d    = rdy_q;
        last_d   = last_q;
        vdata_d  = vdata_q;
        rd_ready = !pclk_q;
        oe_d     = !(tri_s2_q && !tst_s2_q);
        if (!pclk_q)
        begin
            if (rd_valid)
            begin
                pclk_d  = 1'b1;
                rdy_d   = 1'b1;
                vdata_d = rd_word.data;
                last_d  = rd_word.last;
            end
            else if (rdy_q && last_q)
            begin
                pclk_d = 1'b1;
                rdy_d  = 1'b0;
                last_d = 1'b0;
            end
        end
    end

    always_ff @(posedge LINK_CLK or negedge lrst_n_q)
    begin
        if (!lrst_n_q)
        begin
            tri_s1_q <= 1'b0;
            tri_s2_q <= 1'b0;
            tst_s1_q <= 1'b0;
            tst_s2_q <= 1'b0;
            pclk_q   <= 1'b0;
            rdy_q    <= 1'b0;
            last_q   <= 1'b0;
            vdata_q  <= `VDATA_RST;
            oe_q     <= 1'b1;
        end
        else
        begin
            tri_s1_q <= TRISTATE_TEST_INPUT;
            tri_s2_q <= tri_s1_q;
            tst_s1_q <= TEST_MODE;
            tst_s2_q <= tst_s1_q;
            pclk_q   <= pclk_d;
            rdy_q    <= rdy_d;
            last_q   <= last_d;
            vdata_q  <= vdata_d;
            oe_q     <= oe_d;
        end
    end

    assign VID_DATA      = vdata_q;
    assign LINE_VALID    = rdy_q;
    assign PIX_CLK       = pclk_q;
    assign VID_DATA_OE   = oe_q;
    assign LINE_VALID_OE = oe_q;
    assign PIX_CLK_OE    = oe_q;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    sequence s_last_push;
        wr_fire && wr_word.last;
    endsequence

    sequence s_line_restart;
        (state_q == ST_GAP) && (state_d == ST_EMIT);
    endsequence

    data_on_edge_a: assert property (@(posedge LINK_CLK) disable iff (!lrst_n_q)
        !$stable(vdata_q) |-> $rose(pclk_q) && rdy_q)
        else $error("pixel data changed off a clock edge or outside a line");

    valid_on_edge_a: assert property (@(posedge LINK_CLK) disable iff (!lrst_n_q)
        !$stable(rdy_q) |-> $rose(pclk_q))
        else $error("line valid changed without a pixel clock rise");

    width_low_zero_a: assert property (@(posedge MCLK) disable iff (!RESETN)
        wr_fire && (lbits_q == `ADC_CODE_8) |-> wr_word.data[3:0] == 4'h0)
        else $error("low data lines not zero at 8-bit width");

    line_length_a: assert property (@(posedge MCLK) disable iff (!RESETN)
        s_last_push |-> (pcnt_q == (lmode_q ? 13'h1FFF : 13'h07FF)) ##1 (state_q == ST_GAP))
        else $error("line length differs from the scanning mode");

    line_rate_a: assert property (@(posedge MCLK) disable iff (!RESETN)
        s_line_restart |-> timer_q >= 16'(`LINE_MIN_CYC - 1) && timer_q + 16'h0001 >= period)
        else $error("line started before the line period elapsed");

    port_select_a: assert property (@(posedge MCLK) disable iff (!RESETN)
        !pin_s2_q.test |=> CFG_TWO_WIRE == $past(pin_s2_q.sel))
        else $error("configuration port select not followed");

    tristate_pins_a: assert property (@(posedge LINK_CLK) disable iff (!lrst_n_q)
        tri_s2_q && !tst_s2_q |=> !VID_DATA_OE && !LINE_VALID_OE && !PIX_CLK_OE)
        else $error("outputs driven while tristate test is active");

    row_reset_a: assert property (@(posedge MCLK) disable iff (!RESETN)
        pin_s2_q.test |=> ROW0_RESET == $past(pin_s2_q.sel) &&
                          ROW1_RESET == $past(pin_s2_q.tri_test))
        else $error("row resets do not follow pins in test mode");

    left_align_a: assert property (@(posedge MCLK) disable iff (!RESETN)
        wr_fire && (lbits_q == `ADC_CODE_8) |-> wr_word.data[11:4] == PIX_DATA[7:0])
        else $error("pixel word not on the most significant lines");

    line_frame_a: assert property (@(posedge LINK_CLK) disable iff (!lrst_n_q)
        $fell(rdy_q) |-> $past(last_q))
        else $error("line valid fell before the last pixel");

    clk_divide_a: assert property (@(posedge LINK_CLK) disable iff (!lrst_n_q)
        pclk_q |=> !pclk_q)
        else $error("forwarded clock high for more than one cycle");

endmodule : video_port

// ===== rtl/vid_defs.svh
// Constants of the line sensor video output port
`ifndef VID_DEFS_SVH
`define VID_DEFS_SVH

// ****************************************************************
// Widths and depths
// ****************************************************************
`define PIX_W            12
`define WORD_W           13
`define FIFO_DEPTH       8
`define TIMER_W          16
`define PCNT_W           13

// ****************************************************************
// Line lengths, last pixel index per scanning mode
// ****************************************************************
`define HS_LAST_IDX      13'h07FF
`define HR_LAST_IDX      13'h1FFF

// ****************************************************************
// Conversion width codes: 0 is 8 bits, 4 is 12 bits
// ****************************************************************
`define ADC_CODE_MAX     3'h4
`define ADC_CODE_8       3'h0

// ****************************************************************
// Timing
// ****************************************************************
`define MCLK_PERIOD_NS   100
`define LINE_MIN_NS      25000
`define LINE_MIN_CYC     ((`LINE_MIN_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)

// ****************************************************************
// Reset values
// ****************************************************************
`define VDATA_RST        12'h000
`define TIMER_RST        16'h0000
`define PCNT_RST         13'h0000

`endif

// ===== rtl/vid_pkg.sv
// Types shared by the video output port
package vid_pkg;

    // Word carried through the pixel FIFO
    typedef struct packed {
        logic        last;
        logic [11:0] data;
    } pix_word_t;

    // Static control pins, sampled together
    typedef struct packed {
        logic start;
        logic sel;
        logic tri_test;
        logic test;
    } ctl_pins_t;

    // Line generator states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_EMIT = 3'b010,
        ST_GAP  = 3'b100
    } gen_state_t;

endpackage : vid_pkg

// ===== rtl/vid_fifo.sv
// Dual clock pixel FIFO with gray coded pointers
`timescale 1ns/1ns
module vid_fifo #(
    parameter int WIDTH = 13,
    parameter int DEPTH = 8
) (
    // Write side
    input  wire logic             wclk,
    input  wire logic             wrst_n,
    input  wire logic [WIDTH-1:0] wdata,
    input  wire logic             wvalid,
    output logic                  wready,
    // Read side
    input  wire logic             rclk,
    input  wire logic             rrst_n,
    output logic      [WIDTH-1:0] rdata,
    output logic                  rvalid,
    input  wire logic             rready
);
    localparam int AW = $clog2(DEPTH);

    logic [AW:0]      wbin_q;
    logic [AW:0]      wbin_d;
    logic [AW:0]      wgray_q;
    logic [AW:0]      rbin_q;
    logic [AW:0]      rbin_d;
    logic [AW:0]      rgray_q;
    logic [AW:0]      rgray_s1_q;
    logic [AW:0]      rgray_s2_q;
    logic [AW:0]      wgray_s1_q;
    logic [AW:0]      wgray_s2_q;
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic             wfire;
    logic             rfire;

    // ****************************************************************
    // Write side
    // ****************************************************************
    always_comb
    begin
        wready = (wgray_q != {~rgray_s2_q[AW:AW-1], rgray_s2_q[AW-2:0]});
        wfire  = wvalid && wready;
        wbin_d = wfire ? wbin_q + 1'b1 : wbin_q;
    end

    always_ff @(posedge wclk or negedge wrst_n)
    begin
        if (!wrst_n)
        begin
            wbin_q     <= '0;
            wgray_q    <= '0;
            rgray_s1_q <= '0;
            rgray_s2_q <= '0;
        end
        else
        begin
            wbin_q     <= wbin_d;
            wgray_q    <= wbin_d ^ (wbin_d >> 1);
            rgray_s1_q <= rgray_q;
            rgray_s2_q <= rgray_s1_q;
        end
    end

    for (genvar i = 0; i < DEPTH; i++)
    begin : g_mem
        always_ff @(posedge wclk)
        begin
            if (wfire && (wbin_q[AW-1:0] == AW'(i)))
                mem_q[i] <= wdata;
        end
    end

    // ****************************************************************
    // Read side
    // ****************************************************************
    always_comb
    begin
        rvalid = (rgray_q != wgray_s2_q);
        rdata  = mem_q[rbin_q[AW-1:0]];
        rfire  = rvalid && rready;
        rbin_d = rfire ? rbin_q + 1'b1 : rbin_q;
    end

    always_ff @(posedge rclk or negedge rrst_n)
    begin
        if (!rrst_n)
        begin
            rbin_q     <= '0;
            rgray_q    <= '0;
            wgray_s1_q <= '0;
            wgray_s2_q <= '0;
        end
        else
        begin
            rbin_q     <= rbin_d;
            rgray_q    <= rbin_d ^ (rbin_d >> 1);
            wgray_s1_q <= wgray_q;
            wgray_s2_q <= wgray_s1_q;
        end
    end

endmodule : vid_fifo

// ===== dv/grab_model.sv
// Frame grabber model capturing the parallel video stream
`timescale 1ns/1ns
module grab_model (
    // Video pins
    input  wire logic        pix_clk,
    input  wire logic        line_valid,
    input  wire logic [11:0] vid_data,
    // Word expected on every pixel of the current line
    input  wire logic [11:0] exp_word,
    // Capture results
    output int               lines,
    output int               last_len,
    output int               bad_words,
    output realtime          t_start,
    output realtime          t_prev
);
    int          cnt;
    logic        lv_q;
    logic [11:0] held;

    initial
    begin
        lines = 0;
        last_len = 0;
        bad_words = 0;
        t_start = 0;
        t_prev = 0;
        cnt = 0;
        lv_q = 1'b0;
        held = 12'h000;
    end

    // Sample just after the forwarded clock rises; frame lines by line valid
    always
    begin
        @(posedge pix_clk);
        #1;
        held = vid_data;
        if (line_valid === 1'b1)
        begin
            if (!lv_q)
            begin
                t_prev = t_start;
                t_start = $realtime;
                cnt = 0;
            end
            cnt++;
            if (vid_data !== exp_word)
                bad_words++;
        end
        else if (lv_q)
        begin
            last_len = cnt;
            lines++;
        end
        lv_q = (line_valid === 1'b1);
    end

    // Data must stand while the forwarded clock is high
    always
    begin
        @(negedge pix_clk);
        #1;
        if (vid_data !== held)
            bad_words++;
    end
endmodule : grab_model

// ===== dv/video_port_bench.sv
// Self-checking bench of the line sensor video output port
`timescale 1ns/1ns
module video_port_bench;
    logic        mclk        = 1'b0;
    logic        link_clk    = 1'b0;
    logic        resetn      = 1'b0;
    logic [11:0] pix_data    = 12'hABC;
    logic [2:0]  adc_bits    = 3'h0;
    logic        res_mode    = 1'b0;
    logic [15:0] line_period = 16'h2328;
    logic        start       = 1'b0;
    logic        cfg_sel     = 1'b0;
    logic        tri_in      = 1'b0;
    logic        test_mode   = 1'b0;
    logic [11:0] vid_data;
    logic        vid_oe, lv, lv_oe, pclk, pclk_oe, two_wire, row0, row1;
    logic [11:0] exp_word    = 12'h000;
    int          lines, last_len, bad_words;
    realtime     t_start, t_prev;
    realtime     gap_t;
    int          err_total   = 0;
    int          check_count = 0;
    int          codes[6]    = '{0, 1, 2, 3, 4, 7};

    video_port u_dut (
        .MCLK(mclk), .RESETN(resetn), .LINK_CLK(link_clk), .PIX_DATA(pix_data),
        .ADC_BITS(adc_bits), .RES_MODE(res_mode), .LINE_PERIOD(line_period),
        .START(start), .CFG_SEL(cfg_sel), .TRISTATE_TEST_INPUT(tri_in),
        .TEST_MODE(test_mode), .VID_DATA(vid_data), .VID_DATA_OE(vid_oe),
        .LINE_VALID(lv), .LINE_VALID_OE(lv_oe), .PIX_CLK(pclk), .PIX_CLK_OE(pclk_oe),
        .CFG_TWO_WIRE(two_wire), .ROW0_RESET(row0), .ROW1_RESET(row1)
    );

    grab_model u_grab (
        .pix_clk(pclk), .line_valid(lv), .vid_data(vid_data), .exp_word(exp_word),
        .lines(lines), .last_len(last_len), .bad_words(bad_words),
        .t_start(t_start), .t_prev(t_prev)
    );

    initial
    begin
        forever #50 mclk = ~mclk;
    end

    // Link clock 15 ns, offset from the main clock
    initial
    begin
        #3;
        forever
        begin
            #7 link_clk = 1'b1;
            #8 link_clk = 1'b0;
        end
    end

    // ****************************************************************
    // Access tasks
    // ****************************************************************
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    task automatic wrap_up;
        $display("errors %0d checks %0d", err_total, check_count);
        if (err_total == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up

    task automatic set_pins(input logic tm, input logic sel, input logic tri_v);
        @(posedge mclk);
        test_mode <= tm;
        cfg_sel <= sel;
        tri_in <= tri_v;
        repeat (6) @(posedge mclk);
        @(negedge mclk);
    endtask : set_pins

    // Configure one line and wait for the receiver to see it close
    task automatic run_line(input logic [2:0] code, input int len);
        int n;
        int w;
        w = (code > 3'h4) ? 12 : 8 + code;
        n = lines;
        @(posedge mclk);
        adc_bits <= code;
        res_mode <= (len == 8192);
        start <= 1'b1;
        exp_word = (12'hABC & ((12'h001 << w) - 12'h001)) << (12 - w);
        for (int i = 0; i < 20000 && lines == n; i++)
            @(posedge mclk);
        check("line count", lines, n + 1);
        check("line length", last_len, len);
        check("bad words", bad_words, 0);
    endtask : run_line

    // ****************************************************************
    // Tests
    // ****************************************************************
    initial
    begin
        repeat (3) @(posedge mclk);
        @(negedge mclk);
        check("lv in reset", lv, 1'b0);
        check("data in reset", vid_data, 12'h000);
        check("pclk in reset", pclk, 1'b0);
        repeat (3) @(posedge mclk);
        resetn <= 1'b1;
        repeat (20) @(posedge mclk);
        check("lv idle", lv, 1'b0);
        set_pins(1'b0, 1'b0, 1'b1);
        check("oes released", {vid_oe, lv_oe, pclk_oe}, 3'h0);
        check("two wire low", two_wire, 1'b0);
        set_pins(1'b0, 1'b1, 1'b0);
        check("oes driven", {vid_oe, lv_oe, pclk_oe}, 3'h7);
        check("two wire high", two_wire, 1'b1);
        set_pins(1'b1, 1'b0, 1'b1);
        check("rows 01", {row1, row0}, 2'h2);
        check("test oes", {vid_oe, lv_oe, pclk_oe}, 3'h7);
        check("two wire held", two_wire, 1'b1);
        set_pins(1'b1, 1'b1, 1'b0);
        check("rows 10", {row1, row0}, 2'h1);
        set_pins(1'b0, 1'b0, 1'b0);
        foreach (codes[i])
        begin
            run_line(codes[i][2:0], (codes[i] == 7) ? 8192 : 2048);
            gap_t = t_start - t_prev;
            if (i == 1)
                check("line period", gap_t >= 899800.0 && gap_t <= 900200.0, 1'b1);
        end
        start <= 1'b0;
        wrap_up();
    end

    initial
    begin
        repeat (80000) @(posedge mclk);
        err_total++;
        wrap_up();
    end
endmodule : video_port_bench
